// *** design/dbc_cache.sv ***
// Purpose: Segmented buffer cache and read-ahead controller.
// Assumes: One command at a time; medium port answers each request once.
// Notes:   Bookkeeping only; block data moves on a separate path.
// Contract
// (R1) Record the LBA range held by every segment.
// (R2) With read caching on, look in the buffer before any disc access.
// (R3) With read caching off, skip lookup; read medium through a segment. Code still searches read-ahead segments and records no pass-through read.
// (R4) Full hit: answer from buffer, no disc access.
// (R5) Any missing block: read from disc into a segment, then send.
// (R6) Segments are wrap-around, whole blocks, created and removed on demand.
// (R7) Segment size always reads back as all ones.
// (R8) Segment size writes ignored; unchangeable_param_check flag flags an unchangeable change.
// (R9) With read caching on, written data stays cached for later reads.
// (R10) Write first clears overlapping segments, then caches new data.
// (R11) Long writes wrap in their segment, never over uncommitted blocks.
// (R12) With write caching on, good status once data is buffered.
// (R13) Medium failure after early good status raises a deferred error.
// (R14) Synchronize completes only after all earlier writes are committed.
// (R15) Read-ahead fetches blocks past a read; later match is a prefetch hit.
// (R16) Read-ahead disable flag at bit 5; zero enables prefetch.
// (R17) Maximum-prefetch and prefetch-ceiling fields are ignored.
// (R18) Prefetch only when a hit is predicted, stop otherwise.
// (R19) Prefetch and read caching enabled separately.
// (R20) Segmentation independent of the read-cache-disable setting.
// (R21) About 13,000 kbytes of the 16 Mbyte buffer serve as cache.
// (R22) Bookkeeping serves 512, 520, 524 and 528 byte blocks.
// (R23) Hit decided by comparing request range with valid segment ranges.
`timescale 1ns/1ps
`default_nettype none
module dbc_cache #(
  parameter int NSEG     = 4,
  parameter int LBA_W    = 32,
  parameter int LEN_W    = 16,
  parameter int SEG_BLKS = 6144,
  parameter int PF_BLKS  = 64
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic             clk_en,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             cmd_valid,
  output logic                  cmd_ready,
  input  wire logic [1:0]       cmd_op,
  input  wire logic [LBA_W-1:0] cmd_lba,
  input  wire logic [LEN_W-1:0] cmd_len,
  output logic                  rsp_valid,
  input  wire logic             rsp_ready,
  output logic [1:0]            rsp_status,
  output logic [1:0]            rsp_hit,
  output logic                  med_valid,
  input  wire logic             med_ready,
  output logic [1:0]            med_op,
  output logic [LBA_W-1:0]      med_lba,
  output logic [LEN_W-1:0]      med_len,
  input  wire logic             med_done,
  input  wire logic             med_err,
  output logic [9:0]            med_blk_bytes,
  output logic                  deferred_err
);
  localparam int SW = (NSEG > 1) ? $clog2(NSEG) : 1;
  localparam logic [LEN_W-1:0] SEGL = LEN_W'(SEG_BLKS);
  localparam logic [LEN_W-1:0] PFL  = LEN_W'(PF_BLKS);
  localparam logic [SW-1:0]    LASTS = SW'(NSEG - 1);

  // Buffer budget: worst case is the largest block size [R21] [R22]
  if (NSEG < 2 || SEG_BLKS < 1 || SEG_BLKS >= 2 ** LEN_W || PF_BLKS < 1 ||
      PF_BLKS > SEG_BLKS || LBA_W < 8 ||
      longint'(NSEG) * longint'(SEG_BLKS) * longint'(dbc_pkg::BLK_528) > dbc_pkg::CACHE_BYTES ||
      dbc_pkg::CACHE_BYTES > dbc_pkg::PHYS_BYTES) begin : g_bad
    $error("dbc_cache: parameters exceed the cache budget");
  end

  dbc_pkg::dbc_state_e st;
  logic [1:0]       c_op;
  logic [LBA_W-1:0] c_lba;
  logic [LEN_W-1:0] c_len;
  logic [LBA_W-1:0] wr_lba;
  logic [LEN_W-1:0] wr_left;
  logic             early;
  logic             wr_pend;
  logic             pf_pend;
  logic [1:0]       pred;
  logic [LBA_W-1:0] last_end;
  logic [31:0]      ctrl;
  logic [1:0]       bsel;
  logic             st_unch;
  logic [31:0]      chit;
  logic [31:0]      phit;
  logic             rc_off;
  logic             wc_on;
  logic             ra_off;
  logic [NSEG-1:0]  s_v;
  logic [NSEG-1:0]  s_pf;
  logic [NSEG-1:0]  s_d;
  logic [LBA_W-1:0] s_base [NSEG];
  logic [LEN_W-1:0] s_cnt [NSEG];
  logic [LBA_W:0]   s_end [NSEG];
  logic [NSEG-1:0]  hit_v;
  logic [NSEG-1:0]  ovl_v;
  logic [LBA_W:0]   c_end;
  logic [LEN_W-1:0] c_clip;
  logic [LEN_W-1:0] wr_clip;
  logic             is_hit;
  logic             is_phit;
  logic             rd_look;
  logic             wr_look;
  logic             wr_last;
  logic             def_set;
  logic             rec_en;
  logic [LBA_W-1:0] rec_base;
  logic [LEN_W-1:0] rec_cnt;
  logic             rec_pf;
  logic [SW-1:0]    rr;
  logic [SW-1:0]    vic;
  logic [7:0]       aw_a;
  logic             aw_h;
  logic [31:0]      w_d;
  logic [3:0]       w_s;
  logic             w_h;
  logic [31:0]      wmask;
  logic             wr_go;

  assign rc_off = ctrl[dbc_pkg::RC_OFF_B];
  assign wc_on  = ctrl[dbc_pkg::WC_ON_B];
  assign ra_off = ctrl[dbc_pkg::RA_OFF_B];   // Zero lets read-ahead run [R16] [R19]

  // Range compare against every valid segment [R23] [R2]
  assign c_end = {1'b0, c_lba} + (LBA_W + 1)'(c_len);
  always_comb begin
    for (int i = 0; i < NSEG; i++) begin
      s_end[i] = {1'b0, s_base[i]} + (LBA_W + 1)'(s_cnt[i]);
      // Read-ahead segments are searched even with read caching off [R15] [R3]
      hit_v[i] = s_v[i] && (s_pf[i] || !rc_off) && c_lba >= s_base[i] && c_end <= s_end[i];
      ovl_v[i] = s_v[i] && {1'b0, s_base[i]} < c_end && {1'b0, c_lba} < s_end[i];
    end
  end
  assign is_hit  = |hit_v;
  assign is_phit = |(hit_v & s_pf);
  assign c_clip  = (c_len > SEGL) ? SEGL : c_len;
  assign wr_clip = (wr_left > SEGL) ? SEGL : wr_left;
  assign rd_look = st == dbc_pkg::S_LOOK && c_op == dbc_pkg::OP_RD;
  assign wr_look = st == dbc_pkg::S_LOOK && c_op == dbc_pkg::OP_WR;
  assign wr_last = med_done && (med_err || wr_left == med_len);
  assign def_set = st == dbc_pkg::S_MWR && med_done && med_err && early;

  assign cmd_ready = st == dbc_pkg::S_IDLE;
  assign rsp_valid = st == dbc_pkg::S_RSP;

  // Command sequencing and medium requests
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st       <= dbc_pkg::S_IDLE;
      c_op     <= dbc_pkg::OP_RD;
      c_lba    <= '0;
      c_len    <= '0;
      wr_lba   <= '0;
      wr_left  <= '0;
      early    <= 1'b0;
      wr_pend  <= 1'b0;
      pf_pend  <= 1'b0;
      pred     <= dbc_pkg::PRED_RST;
      last_end <= '0;
      rsp_status <= dbc_pkg::STS_GOOD;
      rsp_hit  <= dbc_pkg::HIT_NONE;
      med_valid <= 1'b0;
      med_op   <= dbc_pkg::OP_RD;
      med_lba  <= '0;
      med_len  <= '0;
    end else if (clk_en) begin
      if (med_valid && med_ready)
        med_valid <= 1'b0;
      case (st)
        dbc_pkg::S_IDLE: begin
          if (cmd_valid) begin
            c_op  <= cmd_op;
            c_lba <= cmd_lba;
            c_len <= cmd_len;
            st    <= dbc_pkg::S_LOOK;
          end
        end
        dbc_pkg::S_LOOK: begin
          rsp_status <= dbc_pkg::STS_GOOD;
          rsp_hit    <= dbc_pkg::HIT_NONE;
          case (c_op)
            dbc_pkg::OP_RD: begin
              // Sequential streams and read-ahead hits raise confidence [R18]
              last_end <= c_end[LBA_W-1:0];
              if (c_lba == last_end || is_phit)
                pred <= (pred == dbc_pkg::PRED_MAX) ? pred : pred + 2'h1;
              else
                pred <= (pred == 2'h0) ? pred : pred - 2'h1;
              if (is_hit) begin
                rsp_hit <= is_phit ? dbc_pkg::HIT_PF : dbc_pkg::HIT_CACHE;   // [R4] [R15]
                st      <= dbc_pkg::S_RSP;
              end else begin
                med_op    <= dbc_pkg::OP_RD;   // [R5]
                med_lba   <= c_lba;
                med_len   <= c_len;
                med_valid <= 1'b1;
                st        <= dbc_pkg::S_MRD;
              end
            end
            dbc_pkg::OP_WR: begin
              wr_lba  <= c_lba;
              wr_left <= c_len;
              early   <= wc_on;
              if (wc_on) begin
                wr_pend <= 1'b1;
                st      <= dbc_pkg::S_RSP;   // Good once buffered [R12]
              end else begin
                med_op    <= dbc_pkg::OP_WR;
                med_lba   <= c_lba;
                med_len   <= c_clip;
                med_valid <= 1'b1;
                st        <= dbc_pkg::S_MWR;
              end
            end
            default: st <= dbc_pkg::S_RSP;   // Writes are already committed here [R14]
          endcase
        end
        dbc_pkg::S_MRD: begin
          if (med_done) begin
            rsp_status <= med_err ? dbc_pkg::STS_ERR : dbc_pkg::STS_GOOD;
            pf_pend    <= !ra_off && pred >= dbc_pkg::PRED_ON && !med_err;   // [R16] [R18]
            st         <= dbc_pkg::S_RSP;
          end
        end
        dbc_pkg::S_RSP: begin
          if (rsp_ready) begin
            if (wr_pend) begin
              wr_pend   <= 1'b0;
              med_op    <= dbc_pkg::OP_WR;
              med_lba   <= wr_lba;
              med_len   <= wr_clip;
              med_valid <= 1'b1;
              st        <= dbc_pkg::S_MWR;
            end else if (pf_pend) begin
              // Fixed read-ahead length; host prefetch limits play no part [R17]
              pf_pend   <= 1'b0;
              med_op    <= dbc_pkg::OP_RD;
              med_lba   <= c_end[LBA_W-1:0];
              med_len   <= PFL;
              med_valid <= 1'b1;
              st        <= dbc_pkg::S_PF;
            end else begin
              st <= dbc_pkg::S_IDLE;
            end
          end
        end
        dbc_pkg::S_MWR: begin
          if (med_done) begin
            if (med_err && !early)
              rsp_status <= dbc_pkg::STS_ERR;
            if (wr_last) begin
              st <= early ? dbc_pkg::S_IDLE : dbc_pkg::S_RSP;
            end else begin
              // Commit one segment's worth before reusing its start [R11]
              wr_lba    <= wr_lba + LBA_W'(med_len);
              wr_left   <= wr_left - med_len;
              med_op    <= dbc_pkg::OP_WR;
              med_lba   <= wr_lba + LBA_W'(med_len);
              med_len   <= ((wr_left - med_len) > SEGL) ? SEGL : wr_left - med_len;
              med_valid <= 1'b1;
            end
          end
        end
        dbc_pkg::S_PF: begin
          if (med_done)
            st <= dbc_pkg::S_IDLE;
        end
        default: st <= dbc_pkg::S_IDLE;
      endcase
    end
  end

  // Segment records: created on fill, dropped on write overlap [R1] [R6]
  always_comb begin
    rec_en   = 1'b0;
    rec_base = c_end[LBA_W-1:0] - LBA_W'(c_clip);
    rec_cnt  = c_clip;
    rec_pf   = 1'b0;
    if (wr_look && !rc_off)
      rec_en = 1'b1;   // [R9]
    else if (st == dbc_pkg::S_MRD && med_done && !med_err && !rc_off)
      rec_en = 1'b1;   // Pass-through reads leave nothing behind [R3]
    else if (st == dbc_pkg::S_PF && med_done && !med_err) begin
      rec_en   = 1'b1;
      rec_base = med_lba;
      rec_cnt  = med_len;
      rec_pf   = 1'b1;
    end
  end
  // Victim never holds uncommitted blocks [R11]
  assign vic = !s_d[rr] ? rr : (rr == LASTS) ? '0 : rr + SW'(1);

  // Changing the read-cache flag leaves the segment layout alone [R20]
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_v  <= '0;
      s_pf <= '0;
      s_d  <= '0;
      rr   <= '0;
      for (int i = 0; i < NSEG; i++) begin
        s_base[i] <= '0;
        s_cnt[i]  <= '0;
      end
    end else if (clk_en) begin
      if (wr_look)
        s_v <= s_v & ~ovl_v;   // [R10]
      if (st == dbc_pkg::S_MWR && wr_last)
        s_d <= '0;
      if (rec_en) begin
        s_v[vic]    <= 1'b1;
        s_pf[vic]   <= rec_pf;
        s_d[vic]    <= wr_look;
        s_base[vic] <= rec_base;
        s_cnt[vic]  <= rec_cnt;
        rr          <= (vic == LASTS) ? '0 : vic + SW'(1);
      end
    end
  end

  // AXI4-Lite write channel: address and data taken in either order
  assign s_axi_awready = !aw_h && !s_axi_bvalid;
  assign s_axi_wready  = !w_h && !s_axi_bvalid;
  assign wr_go = aw_h && w_h && !s_axi_bvalid;
  assign wmask = {{8{w_s[3]}}, {8{w_s[2]}}, {8{w_s[1]}}, {8{w_s[0]}}};
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aw_h <= 1'b0;
      aw_a <= '0;
      w_h  <= 1'b0;
      w_d  <= '0;
      w_s  <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dbc_pkg::RESP_OK;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_h <= 1'b1;
        aw_a <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_h <= 1'b1;
        w_d <= s_axi_wdata;
        w_s <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_h <= 1'b0;
        w_h  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_a)
          dbc_pkg::A_CTRL, dbc_pkg::A_SEGSZ, dbc_pkg::A_PFLIM, dbc_pkg::A_STAT,
          dbc_pkg::A_CHIT, dbc_pkg::A_PHIT, dbc_pkg::A_BLKSZ: s_axi_bresp <= dbc_pkg::RESP_OK;
          default: s_axi_bresp <= dbc_pkg::RESP_SLV;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Software-visible control and status
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl    <= dbc_pkg::CTRL_RST;
      bsel    <= dbc_pkg::BSEL_RST;
      med_blk_bytes <= dbc_pkg::BLK_512;
      st_unch <= 1'b0;
      deferred_err <= 1'b0;
      chit    <= '0;
      phit    <= '0;
    end else if (clk_en) begin
      if (wr_go && aw_a == dbc_pkg::A_CTRL)
        ctrl <= (ctrl & ~(wmask & dbc_pkg::CTRL_MASK)) | (w_d & wmask & dbc_pkg::CTRL_MASK);
      if (wr_go && aw_a == dbc_pkg::A_BLKSZ && w_s[0]) begin
        bsel <= w_d[1:0];
        case (w_d[1:0])   // [R22]
          2'h0: med_blk_bytes <= dbc_pkg::BLK_512;
          2'h1: med_blk_bytes <= dbc_pkg::BLK_520;
          2'h2: med_blk_bytes <= dbc_pkg::BLK_524;
          default: med_blk_bytes <= dbc_pkg::BLK_528;
        endcase
      end
      // Sticky flags: a new event outranks a same-cycle clear
      if (wr_go && aw_a == dbc_pkg::A_SEGSZ && ctrl[dbc_pkg::UCHK_B])
        st_unch <= 1'b1;   // [R8]
      else if (wr_go && aw_a == dbc_pkg::A_STAT && w_s[0] && w_d[dbc_pkg::ST_UNCH_B])
        st_unch <= 1'b0;
      if (def_set)
        deferred_err <= 1'b1;   // [R13]
      else if (wr_go && aw_a == dbc_pkg::A_STAT && w_s[0] && w_d[dbc_pkg::ST_DEF_B])
        deferred_err <= 1'b0;
      if (rd_look && is_hit && !is_phit)
        chit <= chit + 32'h1;
      if (rd_look && is_phit)
        phit <= phit + 32'h1;
    end
  end

  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= dbc_pkg::RESP_OK;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= dbc_pkg::RESP_OK;
        s_axi_rdata  <= '0;
        case (s_axi_araddr)
          dbc_pkg::A_CTRL:  s_axi_rdata <= ctrl;
          dbc_pkg::A_SEGSZ: s_axi_rdata <= {16'h0000, dbc_pkg::SEGSZ_RD};   // [R7]
          dbc_pkg::A_PFLIM: s_axi_rdata <= '0;   // [R17]
          dbc_pkg::A_STAT: begin
            s_axi_rdata[dbc_pkg::ST_DEF_B]  <= deferred_err;
            s_axi_rdata[dbc_pkg::ST_UNCH_B] <= st_unch;
            s_axi_rdata[dbc_pkg::ST_DIRT_B] <= |s_d;
          end
          dbc_pkg::A_CHIT:  s_axi_rdata <= chit;
          dbc_pkg::A_PHIT:  s_axi_rdata <= phit;
          dbc_pkg::A_BLKSZ: s_axi_rdata <= {6'h00, med_blk_bytes, 14'h0000, bsel};
          default: s_axi_rresp <= dbc_pkg::RESP_SLV;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  segsz_read_a: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(s_axi_rvalid) && $past(s_axi_araddr) == dbc_pkg::A_SEGSZ |-> s_axi_rdata[15:0] == 16'hFFFF)
    else $error("segment size not all ones");   // [R7]
  hit_no_disc_a: assert property (@(posedge ref_clk) disable iff (srst)
    rd_look && is_hit && clk_en |=> st == dbc_pkg::S_RSP && !med_valid && rsp_hit != dbc_pkg::HIT_NONE)
    else $error("cache hit went to disc");   // [R4]
  miss_disc_a: assert property (@(posedge ref_clk) disable iff (srst)
    rd_look && !is_hit && clk_en |=> st == dbc_pkg::S_MRD && med_valid && med_lba == $past(c_lba))
    else $error("miss did not read medium");   // [R5]
  rcoff_norec_a: assert property (@(posedge ref_clk) disable iff (srst)
    st == dbc_pkg::S_MRD && med_done && rc_off |-> !rec_en)
    else $error("pass-through read was cached");   // [R3]
  early_good_a: assert property (@(posedge ref_clk) disable iff (srst)
    wr_look && wc_on && clk_en |=> rsp_valid && rsp_status == dbc_pkg::STS_GOOD && !med_valid)
    else $error("early good status missing");   // [R12]
  wr_chunk_a: assert property (@(posedge ref_clk) disable iff (srst)
    med_valid && med_op == dbc_pkg::OP_WR |-> med_len <= SEGL)
    else $error("write chunk exceeds segment");   // [R11]
  deferred_a: assert property (@(posedge ref_clk) disable iff (srst)
    def_set && clk_en |=> deferred_err ##1 (deferred_err || $past(wr_go)))
    else $error("deferred error not raised");   // [R13]
  sync_done_a: assert property (@(posedge ref_clk) disable iff (srst)
    rsp_valid && c_op == dbc_pkg::OP_SYNC |-> s_d == '0 && !wr_pend)
    else $error("sync answered with dirty data");   // [R14]
  pf_gate_a: assert property (@(posedge ref_clk) disable iff (srst)
    st == dbc_pkg::S_RSP && rsp_ready && pf_pend && !wr_pend && clk_en |=>
      st == dbc_pkg::S_PF && med_len == PFL && med_lba == $past(c_end[LBA_W-1:0]))
    else $error("read-ahead request wrong");   // [R15]
  inval_a: assert property (@(posedge ref_clk) disable iff (srst)
    wr_look && clk_en |=> (s_v & ~s_d & $past(ovl_v)) == '0)
    else $error("overlapping segment kept");   // [R10]
endmodule
`default_nettype wire

// *** design/dbc_pkg.sv ***
// Purpose: Shared constants for the disk buffer cache controller.
// Assumes: AXI4-Lite register map, 32-bit data, byte addresses.
// Notes:   Bit positions of control fields follow the caching page.
package dbc_pkg;
  localparam logic [7:0]  A_CTRL    = 8'h00;
  localparam logic [7:0]  A_SEGSZ   = 8'h04;
  localparam logic [7:0]  A_PFLIM   = 8'h08;
  localparam logic [7:0]  A_STAT    = 8'h0C;
  localparam logic [7:0]  A_CHIT    = 8'h10;
  localparam logic [7:0]  A_PHIT    = 8'h14;
  localparam logic [7:0]  A_BLKSZ   = 8'h18;
  localparam int          RC_OFF_B  = 0;
  localparam int          WC_ON_B   = 2;
  localparam int          RA_OFF_B  = 5;
  localparam int          UCHK_B    = 8;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0125;
  localparam logic [15:0] SEGSZ_RD  = 16'hFFFF;
  localparam int          ST_DEF_B  = 0;
  localparam int          ST_UNCH_B = 1;
  localparam int          ST_DIRT_B = 2;
  localparam int          BSZ_LO    = 16;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_SLV  = 2'h2;
  localparam logic [1:0]  OP_RD     = 2'h0;
  localparam logic [1:0]  OP_WR     = 2'h1;
  localparam logic [1:0]  OP_SYNC   = 2'h2;
  localparam logic [1:0]  STS_GOOD  = 2'h0;
  localparam logic [1:0]  STS_ERR   = 2'h1;
  localparam logic [1:0]  HIT_NONE  = 2'h0;
  localparam logic [1:0]  HIT_CACHE = 2'h1;
  localparam logic [1:0]  HIT_PF    = 2'h2;
  localparam logic [1:0]  BSEL_RST  = 2'h0;
  localparam logic [9:0]  BLK_512   = 10'h200;
  localparam logic [9:0]  BLK_520   = 10'h208;
  localparam logic [9:0]  BLK_524   = 10'h20C;
  localparam logic [9:0]  BLK_528   = 10'h210;
  localparam longint      PHYS_BYTES  = 64'h0000_0000_0100_0000;
  localparam longint      CACHE_BYTES = 64'h0000_0000_00CB_2000;
  localparam logic [1:0]  PRED_MAX  = 2'h3;
  localparam logic [1:0]  PRED_ON   = 2'h2;
  localparam logic [1:0]  PRED_RST  = 2'h2;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_LOOK = 6'h02,
    S_MRD  = 6'h04,
    S_PF   = 6'h08,
    S_MWR  = 6'h10,
    S_RSP  = 6'h20
  } dbc_state_e;
endpackage

// *** dv/dbc_medium.sv ***
// Purpose: Disc medium stand-in for the buffer cache controller.
// Assumes: One request at a time, finished DLY cycles after it is taken.
// Notes:   fail makes each completion report an error.
`timescale 1ns/1ps
`default_nettype none
module dbc_medium #(parameter int DLY = 3) (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic med_valid,
  input  wire logic fail,
  output logic      med_ready,
  output logic      med_done,
  output logic      med_err
);
  int cnt;
  always_ff @(posedge ref_clk) begin
    med_done <= 1'b0;
    med_err  <= ~med_err;
    if (srst) begin
      med_ready <= 1'b1;
      med_err   <= 1'b0;
      cnt       <= 0;
    end else if (med_valid && med_ready) begin
      med_ready <= 1'b0;
      cnt       <= DLY;
    end else if (cnt == 1) begin
      med_done  <= 1'b1;
      med_err   <= fail;
      med_ready <= 1'b1;
      cnt       <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// *** dv/test_disk_buffer_cache_prefetch.sv ***
// Purpose: Self-checking bench for the buffer cache controller.
// Assumes: Medium stand-in answers every request; rsp_ready is random.
// Notes:   Expected answers are queued and checked as they appear.
`timescale 1ns/1ps
`default_nettype none
module test_disk_buffer_cache_prefetch;
  logic        ref_clk = 1'b0, srst = 1'b1, awv = 1'b0, wv = 1'b0, bready = 1'b1, arv = 1'b0, rready = 1'b1;
  logic        cv = 1'b0, rsp_ready = 1'b0, fail = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, cmd_lba = 32'h0;
  logic [1:0]  cmd_op = 2'h0;
  wire logic   awready, wready, bvalid, arready, rvalid, cmd_ready, rsp_valid, med_valid, med_ready, med_done, med_err;
  wire logic   dfe;
  wire logic [1:0]  bresp, rresp, rsp_status, rsp_hit, med_op;
  wire logic [31:0] rdata, med_lba;
  wire logic [15:0] med_len;
  wire logic [9:0]  blk;
  int          errors = 0, check_count = 0, mcnt = 0, m0 = 0, seed = 10;
  logic [33:0] rq[$];
  logic [3:0]  cq[$];
  logic [1:0]  bq[$];
  logic [15:0] clen = 16'h0004;
  logic [9:0]  bsz[4] = '{dbc_pkg::BLK_512, dbc_pkg::BLK_520, dbc_pkg::BLK_524, dbc_pkg::BLK_528};
  dbc_cache #(.SEG_BLKS(8), .PF_BLKS(8))
  dut (.ref_clk(ref_clk), .srst(srst), .clk_en(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cmd_valid(cv), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_lba(cmd_lba), .cmd_len(clen),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_status(rsp_status), .rsp_hit(rsp_hit),
    .med_valid(med_valid), .med_ready(med_ready), .med_op(med_op), .med_lba(med_lba), .med_len(med_len),
    .med_done(med_done), .med_err(med_err), .med_blk_bytes(blk), .deferred_err(dfe));
  dbc_medium u_med (.ref_clk(ref_clk), .srst(srst), .med_valid(med_valid), .fail(fail), .med_ready(med_ready),
    .med_done(med_done), .med_err(med_err));
  initial forever #5 ref_clk = ~ref_clk;
  task automatic chk(string n, logic [33:0] e, logic [33:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  always @(posedge ref_clk) begin
    rsp_ready <= 1'($random(seed));
    if (med_valid && med_ready) mcnt++;
    if (rvalid && rready) chk("rdata", rq.pop_front(), {rresp, rdata});
    if (bvalid && bready) chk("bresp", 34'(bq.pop_front()), 34'(bresp));
    if (rsp_valid && rsp_ready) chk("rsp", 34'(cq.pop_front()), 34'({rsp_status, rsp_hit}));
  end
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bq.push_back(r);
    do @(negedge ref_clk); while (!(awready && wready));
    @(posedge ref_clk);
    awv <= 1'b0;
    wv <= 1'b0;
    do @(negedge ref_clk); while (!bvalid);
    @(posedge ref_clk);
  endtask
  task automatic rd(logic [7:0] a, logic [33:0] e);
    araddr <= a;
    arv <= 1'b1;
    rq.push_back(e);
    do @(negedge ref_clk); while (!arready);
    @(posedge ref_clk);
    arv <= 1'b0;
    do @(negedge ref_clk); while (!rvalid);
    @(posedge ref_clk);
  endtask
  task automatic cmd(logic [1:0] op, logic [31:0] lba, logic [1:0] st, logic [1:0] hit);
    cmd_op <= op;
    cmd_lba <= lba;
    cv <= 1'b1;
    cq.push_back({st, hit});
    do @(negedge ref_clk); while (!cmd_ready);
    @(posedge ref_clk);
    cv <= 1'b0;
    do @(negedge ref_clk); while (cq.size() != 0 || !cmd_ready);
    @(posedge ref_clk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #100us;
    errors++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rd(dbc_pkg::A_CTRL, {dbc_pkg::RESP_OK, dbc_pkg::CTRL_RST});
    rd(dbc_pkg::A_SEGSZ, {dbc_pkg::RESP_OK, 16'h0, dbc_pkg::SEGSZ_RD});
    wr(dbc_pkg::A_PFLIM, 32'hFFFF_FFFF, dbc_pkg::RESP_OK);
    rd(dbc_pkg::A_PFLIM, {dbc_pkg::RESP_OK, 32'h0});
    wr(8'h1C, 32'h0, dbc_pkg::RESP_SLV);
    wr(dbc_pkg::A_CTRL, 32'h1 << dbc_pkg::UCHK_B, dbc_pkg::RESP_OK);
    wr(dbc_pkg::A_SEGSZ, 32'h0000_0200, dbc_pkg::RESP_OK);
    rd(dbc_pkg::A_SEGSZ, {dbc_pkg::RESP_OK, 16'h0, dbc_pkg::SEGSZ_RD});
    rd(dbc_pkg::A_STAT, {dbc_pkg::RESP_OK, 32'h2});
    for (int i = 0; i < 4; i++) begin
      wr(dbc_pkg::A_BLKSZ, 32'(i), dbc_pkg::RESP_OK);
      rd(dbc_pkg::A_BLKSZ, {dbc_pkg::RESP_OK, 6'h0, bsz[i], 14'h0, 2'(i)});
      chk("blk_bytes", 34'(bsz[i]), 34'(blk));
    end
    wr(dbc_pkg::A_BLKSZ, 32'h0, dbc_pkg::RESP_OK);
    wr(dbc_pkg::A_CTRL, 32'h0, dbc_pkg::RESP_OK);
    $display("register test done");
    m0 = mcnt;
    cmd(dbc_pkg::OP_RD, 32'd1000, dbc_pkg::STS_GOOD, dbc_pkg::HIT_NONE);
    chk("med_reqs", 34'(m0 + 1), 34'(mcnt));
    m0 = mcnt;
    cmd(dbc_pkg::OP_RD, 32'd1004, dbc_pkg::STS_GOOD, dbc_pkg::HIT_NONE);
    chk("med_reqs", 34'(m0 + 2), 34'(mcnt));
    cmd(dbc_pkg::OP_RD, 32'd1008, dbc_pkg::STS_GOOD, dbc_pkg::HIT_PF);
    wr(dbc_pkg::A_CTRL, 32'h1 << dbc_pkg::RA_OFF_B, dbc_pkg::RESP_OK);
    m0 = mcnt;
    cmd(dbc_pkg::OP_RD, 32'd1000, dbc_pkg::STS_GOOD, dbc_pkg::HIT_CACHE);
    chk("med_reqs", 34'(m0), 34'(mcnt));
    wr(dbc_pkg::A_CTRL, 32'h21, dbc_pkg::RESP_OK);
    m0 = mcnt;
    cmd(dbc_pkg::OP_RD, 32'd1000, dbc_pkg::STS_GOOD, dbc_pkg::HIT_NONE);
    chk("med_reqs", 34'(m0 + 1), 34'(mcnt));
    $display("read test done");
    wr(dbc_pkg::A_CTRL, 32'h24, dbc_pkg::RESP_OK);
    fail <= 1'b1;
    cmd(dbc_pkg::OP_WR, 32'd2000, dbc_pkg::STS_GOOD, dbc_pkg::HIT_NONE);
    chk("deferred_err", 34'h1, 34'(dfe));
    wr(dbc_pkg::A_STAT, 32'h1, dbc_pkg::RESP_OK);
    chk("deferred_err", 34'h0, 34'(dfe));
    fail <= 1'b0;
    cmd(dbc_pkg::OP_SYNC, 32'd0, dbc_pkg::STS_GOOD, dbc_pkg::HIT_NONE);
    wr(dbc_pkg::A_CTRL, 32'h20, dbc_pkg::RESP_OK);
    cmd(dbc_pkg::OP_WR, 32'd1002, dbc_pkg::STS_GOOD, dbc_pkg::HIT_NONE);
    cmd(dbc_pkg::OP_RD, 32'd1000, dbc_pkg::STS_GOOD, dbc_pkg::HIT_NONE);
    cmd(dbc_pkg::OP_RD, 32'd1002, dbc_pkg::STS_GOOD, dbc_pkg::HIT_CACHE);
    clen <= 16'h0014;
    m0 = mcnt;
    cmd(dbc_pkg::OP_WR, 32'd3000, dbc_pkg::STS_GOOD, dbc_pkg::HIT_NONE);
    chk("med_reqs", 34'(m0 + 3), 34'(mcnt));
    $display("write test done");
    end_sim();
  end
endmodule
`default_nettype wire
